// >>> shared/brc_params.svh
`ifndef BRC_PARAMS_SVH
`define BRC_PARAMS_SVH
// Function
// - A die temperature above the shutdown limit turns every buck off and blocks re-enable until it has cooled.
// - Each enabled buck target follows a monotonic soft-start ramp of 400 us before reaching the programmed voltage.
// - The target code comes from the primary bank while the bank-select pin is low, else from the alternate bank.
// - A buck turns on at a 0-to-1 edge of its enable bit and off at a 1-to-0 edge, never on the level.
// - A 3-bit wait code gives a turn-on delay of 0, 2, 4, 8, 16, 32, 64 or 128 ms.
// - Mode bit 0 keeps light-load power saving, mode bit 1 forces fixed-frequency PWM at every load.
// - The power-good flag reads 0 while the output sits below the threshold 7% under the programmed voltage.
// - An unmasked buck in regulation whose output drops below the threshold pulls the active-low interrupt low.
// - The interrupt holds until the buck is off or back in regulation and its power-good flag has been read.
// - The 6-bit code maps its upper three bits to a range base and its lower three bits to a step of that range.
// - After power-up each buck regulates to its built-in default code until the host writes another.
// - Register access arrives as serial-slave single-byte writes and reads, here as write and read strobes.

// Clock and timing
`define BRC_CLK_MHZ 250
`define BRC_RAMP_US 400
`define BRC_RAMP_CYC (`BRC_RAMP_US * `BRC_CLK_MHZ)
`define BRC_RAMP_STEPS 256
`define BRC_WAIT_UNIT_MS 2
`define BRC_WAIT_UNIT_CYC (`BRC_WAIT_UNIT_MS * 1000 * `BRC_CLK_MHZ)
`define BRC_WAIT_MAX_SHIFT 6

// Buck count and field widths
`define BRC_NUM_BUCKS 3
`define BRC_CODE_W 6
`define BRC_MV_W 12
`define BRC_WAIT_W 3

// Reset codes, third buck in the upper bits
`define BRC_DEF_PRIMARY 18'h24E58
`define BRC_DEF_ALTERNATE 18'h24E58

// Voltage code ranges in mV
`define BRC_BASE_MV_0 12'd600
`define BRC_BASE_MV_1 12'd800
`define BRC_BASE_MV_2 12'd1000
`define BRC_BASE_MV_3 12'd1200
`define BRC_BASE_MV_4 12'd1600
`define BRC_BASE_MV_5 12'd2000
`define BRC_BASE_MV_6 12'd2400
`define BRC_BASE_MV_7 12'd3200
`define BRC_STEP_MV_FINE 12'd25
`define BRC_STEP_MV_MID 12'd50
`define BRC_STEP_MV_COARSE 12'd100
`endif

// >>> shared/brc_pkg.sv
`include "brc_params.svh"
package brc_pkg;
	typedef enum logic [1:0] {CH_OFF, CH_WAIT, CH_RAMP, CH_ON} brc_chan_state_type;
	typedef logic [`BRC_CODE_W-1:0] brc_code_type;
	typedef logic [`BRC_MV_W-1:0] brc_mv_type;

	function automatic brc_mv_type brc_code_to_mv(input brc_code_type code);
		brc_mv_type base;
		brc_mv_type step;
		case (code[5:3])
			3'h0: base = `BRC_BASE_MV_0;
			3'h1: base = `BRC_BASE_MV_1;
			3'h2: base = `BRC_BASE_MV_2;
			3'h3: base = `BRC_BASE_MV_3;
			3'h4: base = `BRC_BASE_MV_4;
			3'h5: base = `BRC_BASE_MV_5;
			3'h6: base = `BRC_BASE_MV_6;
			default: base = `BRC_BASE_MV_7;
		endcase
		if (code[5:3] < 3'h3) begin
			step = `BRC_STEP_MV_FINE;
		end else if (code[5:3] < 3'h6) begin
			step = `BRC_STEP_MV_MID;
		end else begin
			step = `BRC_STEP_MV_COARSE;
		end
		return brc_mv_type'(base + step * brc_mv_type'(code[2:0]));
	endfunction
endpackage

// >>> shared/brc_chan_if.sv
`timescale 1ns/1ps
interface brc_chan_if;
	logic enable_level;
	logic [2:0] wait_code;
	logic lockout;
	logic [11:0] target_mv;
	logic [11:0] ramp_mv;
	logic powered;
	logic settled;
	modport ctrl (output enable_level, output wait_code, output lockout, output target_mv,
		input ramp_mv, input powered, input settled);
	modport chan (input enable_level, input wait_code, input lockout, input target_mv,
		output ramp_mv, output powered, output settled);
endinterface

// >>> hdl/brc_channel.sv
`timescale 1ns/1ps
`include "brc_params.svh"
module brc_channel import brc_pkg::*; #(
	parameter int RAMP_CYC = `BRC_RAMP_CYC,
	parameter int WAIT_UNIT_CYC = `BRC_WAIT_UNIT_CYC
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	brc_chan_if.chan ch
);
	localparam int STEP_CYC = (RAMP_CYC + `BRC_RAMP_STEPS - 1) / `BRC_RAMP_STEPS;
	localparam int STEP_W = $clog2(STEP_CYC + 1);
	localparam int WCW = $clog2(WAIT_UNIT_CYC * (1 << `BRC_WAIT_MAX_SHIFT) + 1);

	if (RAMP_CYC < `BRC_RAMP_STEPS || WAIT_UNIT_CYC < 1) begin : g_bad_timing
		$error("Ramp or wait count too small");
	end

	brc_chan_state_type state;
	brc_chan_state_type next_state;
	logic enable_prev;
	logic [WCW-1:0] wait_cnt;
	logic [STEP_W-1:0] step_cnt;
	logic [8:0] frac;

	// Edge detection on the enable bit
	wire rise = ch.enable_level & ~enable_prev;
	wire fall = ~ch.enable_level & enable_prev;
	wire [WCW-1:0] wait_load = (ch.wait_code == 3'h0) ? '0 :
		WCW'(WAIT_UNIT_CYC) << (ch.wait_code - 3'h1);
	wire step_end = (step_cnt == STEP_W'(STEP_CYC - 1));
	wire frac_done = (frac == 9'(`BRC_RAMP_STEPS));
	wire [20:0] ramp_prod = 21'(ch.target_mv) * 21'(frac);
	wire [11:0] next_ramp_mv = (next_state == CH_ON) ? ch.target_mv :
		(next_state == CH_RAMP) ? ramp_prod[19:8] : 12'h000;

	always_comb begin
		next_state = state;
		case (state)
			CH_OFF: begin
				if (rise && !ch.lockout) begin
					next_state = (ch.wait_code == 3'h0) ? CH_RAMP : CH_WAIT;
				end
			end
			CH_WAIT: begin
				if (wait_cnt == WCW'(1)) begin
					next_state = CH_RAMP;
				end
			end
			CH_RAMP: begin
				if (frac_done) begin
					next_state = CH_ON;
				end
			end
			CH_ON: begin
				next_state = CH_ON;
			end
			default: begin
				next_state = CH_OFF;
			end
		endcase
		if (fall || ch.lockout) begin
			next_state = CH_OFF;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= CH_OFF;
			enable_prev <= 1'b0;
			wait_cnt <= '0;
			step_cnt <= '0;
			frac <= 9'h000;
			ch.ramp_mv <= 12'h000;
			ch.powered <= 1'b0;
			ch.settled <= 1'b0;
		end else begin
			state <= next_state;
			enable_prev <= ch.enable_level;
			wait_cnt <= (state == CH_WAIT) ? wait_cnt - WCW'(1) : wait_load;
			if (state == CH_RAMP && !frac_done) begin
				step_cnt <= step_end ? '0 : step_cnt + STEP_W'(1);
				frac <= step_end ? frac + 9'h001 : frac;
			end else if (state != CH_RAMP) begin
				step_cnt <= '0;
				frac <= 9'h000;
			end
			ch.ramp_mv <= next_ramp_mv;
			ch.powered <= (next_state == CH_RAMP) || (next_state == CH_ON);
			ch.settled <= (next_state == CH_ON);
		end
	end
endmodule

// >>> hdl/brc_top.sv
`timescale 1ns/1ps
`include "brc_params.svh"
module brc_top import brc_pkg::*; #(
	parameter int RAMP_CYC = `BRC_RAMP_CYC,
	parameter int WAIT_UNIT_CYC = `BRC_WAIT_UNIT_CYC,
	parameter logic [17:0] DEF_PRIMARY = `BRC_DEF_PRIMARY,
	parameter logic [17:0] DEF_ALTERNATE = `BRC_DEF_ALTERNATE
) (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_voltage_bank_select,
	input wire logic i_temp_over_limit,
	input wire logic i_temp_recovered,
	input wire logic [2:0] i_output_low,
	input wire logic [2:0] i_enable,
	input wire logic [2:0] i_force_pwm,
	input wire logic [2:0] i_fault_irq_unmask,
	input wire logic [2:0][2:0] i_wait_code,
	input wire logic [5:0] i_code_wdata,
	input wire logic [2:0] i_primary_wr,
	input wire logic [2:0] i_alternate_wr,
	input wire logic [2:0] i_pg_read,
	output logic o_interrupt_out_n,
	output logic o_thermal_lockout,
	output logic [2:0] o_power_good,
	output logic [2:0] o_buck_on,
	output logic [2:0] o_regulating,
	output logic [2:0] o_force_pwm,
	output logic [2:0][5:0] o_primary_voltage_code,
	output logic [2:0][5:0] o_alternate_voltage_code,
	output logic [2:0][5:0] o_target_voltage_code,
	output logic [2:0][11:0] o_ramp_mv
);
	if (`BRC_NUM_BUCKS != 3) begin : g_bad_count
		$error("Port layout serves three bucks");
	end

	// Pin synchronisers: bank select, two thermal comparators, three output comparators
	logic [5:0] pin_meta;
	logic [5:0] pin_sync;
	wire [5:0] pin_raw = {i_output_low, i_temp_recovered, i_temp_over_limit, i_voltage_bank_select};
	wire bank_alt = pin_sync[0];
	wire temp_over = pin_sync[1];
	wire temp_recovered = pin_sync[2];
	wire [2:0] output_low = pin_sync[5:3];

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pin_meta <= 6'h00;
			pin_sync <= 6'h00;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// Thermal lockout, over-limit wins over recovery
	logic lockout;
	wire next_lockout = temp_over | (lockout & ~temp_recovered);

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lockout <= 1'b0;
		end else begin
			lockout <= next_lockout;
		end
	end

	assign o_thermal_lockout = lockout;

	// Per-buck code banks, target selection and channel
	brc_chan_if ch[3] ();
	logic [2:0] fault;
	logic [2:0] read_seen;
	wire [2:0] fault_set;
	wire [2:0] fault_release;
	wire [2:0] next_fault;
	wire [2:0] next_read_seen;
	wire [2:0] powered;
	wire [2:0] settled;

	for (genvar gi = 0; gi < 3; gi++) begin : g_buck
		logic [5:0] primary;
		logic [5:0] alternate;
		logic [5:0] target;
		wire [5:0] next_target = bank_alt ? alternate : primary;

		always_ff @(posedge i_mclk or negedge i_rst_n) begin
			if (!i_rst_n) begin
				primary <= DEF_PRIMARY[gi*6 +: 6];
				alternate <= DEF_ALTERNATE[gi*6 +: 6];
				target <= DEF_PRIMARY[gi*6 +: 6];
			end else begin
				if (i_primary_wr[gi]) begin
					primary <= i_code_wdata;
				end
				if (i_alternate_wr[gi]) begin
					alternate <= i_code_wdata;
				end
				target <= next_target;
			end
		end

		assign ch[gi].enable_level = i_enable[gi];
		assign ch[gi].wait_code = i_wait_code[gi];
		assign ch[gi].lockout = lockout;
		assign ch[gi].target_mv = brc_code_to_mv(target);
		assign powered[gi] = ch[gi].powered;
		assign settled[gi] = ch[gi].settled;
		assign o_ramp_mv[gi] = ch[gi].ramp_mv;
		assign o_primary_voltage_code[gi] = primary;
		assign o_alternate_voltage_code[gi] = alternate;
		assign o_target_voltage_code[gi] = target;

		brc_channel #(
			.RAMP_CYC(RAMP_CYC),
			.WAIT_UNIT_CYC(WAIT_UNIT_CYC)
		) u_channel (
			.i_mclk(i_mclk),
			.i_rst_n(i_rst_n),
			.ch(ch[gi])
		);
	end

	assign o_buck_on = powered;
	assign o_regulating = settled;

	// Fault latch: a drop on an unmasked, settled buck; set wins over release
	assign fault_set = i_fault_irq_unmask & settled & output_low;
	assign fault_release = read_seen & (~powered | ~output_low);
	assign next_fault = fault_set | (fault & ~fault_release);
	assign next_read_seen = ~fault_set & next_fault & (read_seen | (fault & i_pg_read));

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault <= 3'h0;
			read_seen <= 3'h0;
			o_interrupt_out_n <= 1'b1;
			o_power_good <= 3'h0;
			o_force_pwm <= 3'h0;
		end else begin
			fault <= next_fault;
			read_seen <= next_read_seen;
			o_interrupt_out_n <= ~|next_fault;
			o_power_good <= ~output_low;
			o_force_pwm <= i_force_pwm;
		end
	end
endmodule

// >>> test/brc_top_chk.sv
`timescale 1ns/1ps
module brc_top_chk (
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_temp_over_limit,
	input wire logic [2:0] i_output_low,
	input wire logic [2:0] i_enable,
	input wire logic [2:0] i_force_pwm,
	input wire logic [2:0] i_fault_irq_unmask,
	input wire logic o_interrupt_out_n,
	input wire logic o_thermal_lockout,
	input wire logic [2:0] o_power_good,
	input wire logic [2:0] o_buck_on,
	input wire logic [2:0] o_regulating,
	input wire logic [2:0] o_force_pwm,
	input wire logic [2:0][11:0] o_ramp_mv
);
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	sequence s_fault;
		(i_fault_irq_unmask[0] && o_regulating[0] && i_output_low[0] && i_enable[0]) [*5];
	endsequence
	a_lockout_rise: assert property ($rose(i_temp_over_limit) |-> ##[1:5] o_thermal_lockout)
		else $error("lockout late");
	a_lockout_off: assert property (o_thermal_lockout [*3] |-> o_buck_on == 3'h0)
		else $error("buck on in lockout");
	a_ramp_rising: assert property (o_buck_on[0] && $past(o_buck_on[0]) && !o_regulating[0]
		|-> o_ramp_mv[0] >= $past(o_ramp_mv[0])) else $error("ramp fell");
	a_fall_off: assert property ($fell(i_enable[0]) |-> ##[1:2] !o_buck_on[0])
		else $error("no turn off");
	a_mode_follow: assert property ($stable(i_force_pwm) [*2] |-> o_force_pwm == i_force_pwm)
		else $error("mode wrong");
	a_pg_low: assert property (i_output_low[0] [*4] |-> !o_power_good[0])
		else $error("pg high");
	a_irq_raise: assert property (s_fault |-> !o_interrupt_out_n)
		else $error("irq missing");
	a_irq_hold: assert property (s_fault |=> !o_interrupt_out_n)
		else $error("irq dropped");
	cover property ($rose(o_buck_on[0]));
	cover property ($fell(o_interrupt_out_n));
	cover property ($rose(o_thermal_lockout));
endmodule
bind brc_top brc_top_chk u_chk (.*);

// >>> test/brc_host.sv
`timescale 1ns/1ps
module brc_host (
	input wire logic i_mclk,
	output logic [2:0] o_enable,
	output logic [5:0] o_code_wdata,
	output logic [2:0] o_primary_wr,
	output logic [2:0] o_alternate_wr,
	output logic [2:0] o_pg_read
);
	initial begin
		{o_enable, o_code_wdata, o_primary_wr, o_alternate_wr, o_pg_read} = 18'h0;
	end
	// Enable as 0 then 1, disable as 1 then 0
	task automatic set_on(input int b, input logic v);
		o_enable[b] <= ~v;
		@(posedge i_mclk);
		o_enable[b] <= v;
		@(posedge i_mclk);
	endtask
	// Byte write or flag read as one strobe
	task automatic strobe(input int kind, input int b, input logic [5:0] c);
		o_code_wdata <= c;
		if (kind == 0) begin
			o_primary_wr[b] <= 1'b1;
		end else if (kind == 1) begin
			o_alternate_wr[b] <= 1'b1;
		end else begin
			o_pg_read[b] <= 1'b1;
		end
		@(posedge i_mclk);
		{o_primary_wr, o_alternate_wr, o_pg_read} <= 9'h0;
		o_code_wdata <= ~c;
		@(posedge i_mclk);
	endtask
endmodule

// >>> test/brc_tb_top.sv
`timescale 1ns/1ps
`include "brc_params.svh"
module brc_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic bank = 1'b0;
	logic over = 1'b0;
	logic recov = 1'b0;
	logic [2:0] low = 3'h0;
	logic [2:0] pwm = 3'h0;
	logic [2:0] unmask = 3'h0;
	logic [2:0][2:0] waitc = 9'h0;
	logic [2:0] en, pwr, awr, pgr, pg, on, rdy, pwm_o;
	logic [5:0] wdata;
	logic irq_n, lock;
	logic [2:0][5:0] pcode, acode, tcode;
	logic [2:0][11:0] ramp;
	logic [2:0][5:0] defa = `BRC_DEF_ALTERNATE;
	int n_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	int t, e;
	always #2 clk = ~clk;
	brc_host host (.i_mclk(clk), .o_enable(en), .o_code_wdata(wdata), .o_primary_wr(pwr),
		.o_alternate_wr(awr), .o_pg_read(pgr));
	brc_top #(.RAMP_CYC(512), .WAIT_UNIT_CYC(4)) dut (.i_mclk(clk), .i_rst_n(rst_n),
		.i_voltage_bank_select(bank), .i_temp_over_limit(over), .i_temp_recovered(recov),
		.i_output_low(low), .i_enable(en), .i_force_pwm(pwm), .i_fault_irq_unmask(unmask),
		.i_wait_code(waitc), .i_code_wdata(wdata), .i_primary_wr(pwr), .i_alternate_wr(awr),
		.i_pg_read(pgr), .o_interrupt_out_n(irq_n), .o_thermal_lockout(lock), .o_power_good(pg),
		.o_buck_on(on), .o_regulating(rdy), .o_force_pwm(pwm_o), .o_primary_voltage_code(pcode),
		.o_alternate_voltage_code(acode), .o_target_voltage_code(tcode), .o_ramp_mv(ramp));
	task automatic chk(input logic [17:0] s, input logic [17:0] x, input string n);
		n_tests++;
		if (s !== x) begin
			n_errors++;
			$display("MISMATCH %s expected %0h seen %0h", n, x, s);
		end
	endtask
	task automatic wait_hi(input logic sel, output int c);
		c = 0;
		while ((sel ? rdy[0] : on[0]) !== 1'b1 && c < 2000) begin
			@(posedge clk);
			c++;
		end
	endtask
	function automatic logic [11:0] mv(input logic [5:0] c);
		logic [11:0] b[8] = '{12'h258, 12'h320, 12'h3E8, 12'h4B0, 12'h640, 12'h7D0, 12'h960, 12'hC80};
		return b[c[5:3]] + (c[5:3] < 3 ? 12'h19 : c[5:3] < 6 ? 12'h32 : 12'h64) * c[2:0];
	endfunction
	task automatic wrap_up;
		if (n_errors == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({irq_n, on}, 4'h8, "reset outs");
		chk(tcode, `BRC_DEF_PRIMARY, "tcode");
		chk(acode, `BRC_DEF_ALTERNATE, "acode");
		for (int w = 0; w < 8; w++) begin
			waitc[0] <= w[2:0];
			host.set_on(0, 1'b1);
			wait_hi(1'b0, t);
			e = w ? 4 << (w - 1) : 0;
			chk(t >= e && t <= e + 4, 1'b1, "wait");
			chk(ramp[0], 12'h0, "ramp start");
			host.set_on(0, 1'b0);
		end
		waitc[0] <= 3'h0;
		host.set_on(0, 1'b1);
		wait_hi(1'b0, t);
		wait_hi(1'b1, t);
		chk(t >= 500 && t <= 530, 1'b1, "ramp time");
		chk(ramp[0], mv(6'h18), "ramp end");
		for (int r = 0; r < 8; r++) begin
			host.strobe(0, 0, {r[2:0], 3'h7 - r[2:0]});
			repeat (3) @(posedge clk);
			chk(ramp[0], mv({r[2:0], 3'h7 - r[2:0]}), "code mv");
		end
		chk(pcode[0], 6'h38, "pcode");
		host.strobe(1, 0, 6'h3F);
		repeat (3) @(posedge clk);
		chk(tcode[0], 6'h38, "bank low");
		chk(acode[0], 6'h3F, "acode write");
		bank <= 1'b1;
		repeat (6) @(posedge clk);
		chk(tcode[0], 6'h3F, "bank high");
		chk(ramp[0], mv(6'h3F), "top code");
		for (int m = 0; m < 8; m++) begin
			pwm <= m[2:0];
			repeat (3) @(posedge clk);
			chk(pwm_o, m[2:0], "mode");
		end
		low <= 3'h1;
		repeat (6) @(posedge clk);
		chk({pg[0], irq_n}, 2'h1, "masked");
		low <= 3'h0;
		repeat (6) @(posedge clk);
		unmask <= 3'h1;
		host.strobe(2, 0, 6'h0);
		repeat (6) @(posedge clk);
		chk({pg[0], irq_n}, 2'h3, "pg");
		low <= 3'h1;
		repeat (6) @(posedge clk);
		chk(irq_n, 1'b0, "irq low");
		low <= 3'h0;
		repeat (6) @(posedge clk);
		chk(irq_n, 1'b0, "irq held");
		host.strobe(2, 0, 6'h0);
		repeat (4) @(posedge clk);
		chk(irq_n, 1'b1, "irq clear");
		low <= 3'h1;
		repeat (6) @(posedge clk);
		host.set_on(0, 1'b0);
		repeat (3) @(posedge clk);
		chk({irq_n, on[0]}, 2'h0, "irq off held");
		host.strobe(2, 0, 6'h0);
		repeat (4) @(posedge clk);
		chk(irq_n, 1'b1, "irq off clear");
		low <= 3'h0;
		over <= 1'b1;
		repeat (6) @(posedge clk);
		chk({lock, on[0]}, 2'h2, "lockout");
		host.set_on(0, 1'b1);
		repeat (4) @(posedge clk);
		chk(on[0], 1'b0, "locked");
		over <= 1'b0;
		recov <= 1'b1;
		repeat (6) @(posedge clk);
		recov <= 1'b0;
		chk({lock, on[0]}, 2'h0, "cooled");
		host.set_on(0, 1'b1);
		wait_hi(1'b0, t);
		chk(on[0], 1'b1, "re-enable");
		host.set_on(2, 1'b1);
		repeat (530) @(posedge clk);
		chk({rdy[2], on[1]}, 2'h2, "third on");
		chk(ramp[2], mv(defa[2]), "third code");
		wrap_up();
	end
endmodule
